// file: core/ipl_pkg.sv
// register map, field masks and source order of the interrupt priority level block
package ipl_pkg;
    // register addresses on the special-function register port
    localparam logic [7:0] IPL_ADDR_ENABLE_A = 8'hA8;
    localparam logic [7:0] IPL_ADDR_ENABLE_B = 8'hB1;
    localparam logic [7:0] IPL_ADDR_LOW_B    = 8'hB2;
    localparam logic [7:0] IPL_ADDR_HIGH_B   = 8'hB3;
    localparam logic [7:0] IPL_ADDR_HIGH_A   = 8'hB7;
    localparam logic [7:0] IPL_ADDR_LOW_A    = 8'hB8;
    // implemented bits; everything else is reserved and reads as zero
    localparam logic [7:0] IPL_MASK_A        = 8'h7F;
    localparam logic [7:0] IPL_MASK_B        = 8'h5F;
    localparam logic [7:0] IPL_MASK_ENABLE_A = 8'hFF;
    localparam logic [7:0] IPL_MASK_ENABLE_B = 8'h5F;
    localparam int unsigned IPL_GLOBAL_EN_BIT = 7;
    // reset values of all registers
    localparam logic [7:0] IPL_RESET_VALUE   = 8'h00;
    // sources, index is the fixed polling order
    localparam int unsigned IPL_NUM_SRC = 13;
    localparam int unsigned IPL_IDX_W   = 4;
    localparam int unsigned IPL_LVL_W   = 2;
    localparam int unsigned IPL_NUM_LVL = 4;
endpackage

// file: core/ipl_levels.sv
// interrupt priority level registers with enable gating and level arbitration
// Notes on behaviour
// [RULE_01] first high register at B7h holds level MSBs of seven core sources
// [RULE_02] first low register at B8h holds matching level LSBs, same positions
// [RULE_03] second high register at B3h holds level MSBs of six peripheral sources
// [RULE_04] second low register at B2h holds matching LSBs, same positions
// [RULE_05] source level is high bit as MSB and low bit as LSB
// [RULE_06] bit 7 of first pair reserved; software never writes one
// [RULE_07] bits 7 and 5 of second pair read zero; never written one
// [RULE_08] only sources with global and individual enable set take part
// [RULE_09] 11 highest; higher level preempts; ties follow polling order
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ipl_levels
    import ipl_pkg::*;
(
    // clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_arst_n,
    // register port
    input  wire logic [7:0]             i_addr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [7:0]             o_rdata,
    // requests from peripherals, polling order index
    input  wire logic [IPL_NUM_SRC-1:0] i_irq_pend,
    // core side
    input  wire logic                   i_irq_ack,
    input  wire logic                   i_irq_ret,
    output logic                        o_irq_valid,
    output logic      [IPL_IDX_W-1:0]   o_irq_index,
    output logic      [IPL_LVL_W-1:0]   o_irq_level,
    output logic      [IPL_NUM_LVL-1:0] o_in_service
);

    // register state
    logic [7:0] high_a_q, high_a_d;
    logic [7:0] low_a_q, low_a_d;
    logic [7:0] high_b_q, high_b_d;
    logic [7:0] low_b_q, low_b_d;
    logic [7:0] enable_a_q, enable_a_d;
    logic [7:0] enable_b_q, enable_b_d;
    logic [7:0] rdata_q, rdata_d;

    // register writes; reserved bits are masked off so they never hold a one
    always_comb begin
        high_a_d   = high_a_q;
        low_a_d    = low_a_q;
        high_b_d   = high_b_q;
        low_b_d    = low_b_q;
        enable_a_d = enable_a_q;
        enable_b_d = enable_b_q;
        if (i_wr) begin
            case (i_addr)
                // [RULE_01] first high register
                IPL_ADDR_HIGH_A: high_a_d = i_wdata & IPL_MASK_A;
                // [RULE_02] first low register
                IPL_ADDR_LOW_A: low_a_d = i_wdata & IPL_MASK_A;
                // [RULE_03] second high register
                IPL_ADDR_HIGH_B: high_b_d = i_wdata & IPL_MASK_B;
                // [RULE_04] second low register
                IPL_ADDR_LOW_B: low_b_d = i_wdata & IPL_MASK_B;
                // [RULE_08] enable registers
                IPL_ADDR_ENABLE_A: enable_a_d = i_wdata & IPL_MASK_ENABLE_A;
                IPL_ADDR_ENABLE_B: enable_b_d = i_wdata & IPL_MASK_ENABLE_B;
                default: ;
            endcase
        end
    end

    // read path; reserved bit 7 of the first pair reads zero, a stable choice
    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            case (i_addr)
                // [RULE_06] first pair, reserved bit masked
                IPL_ADDR_HIGH_A: rdata_d = high_a_q & IPL_MASK_A;
                IPL_ADDR_LOW_A: rdata_d = low_a_q & IPL_MASK_A;
                // [RULE_07] second pair, reserved bits read zero
                IPL_ADDR_HIGH_B: rdata_d = high_b_q & IPL_MASK_B;
                IPL_ADDR_LOW_B: rdata_d = low_b_q & IPL_MASK_B;
                IPL_ADDR_ENABLE_A: rdata_d = enable_a_q;
                IPL_ADDR_ENABLE_B: rdata_d = enable_b_q & IPL_MASK_ENABLE_B;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            high_a_q   <= IPL_RESET_VALUE;
            low_a_q    <= IPL_RESET_VALUE;
            high_b_q   <= IPL_RESET_VALUE;
            low_b_q    <= IPL_RESET_VALUE;
            enable_a_q <= IPL_RESET_VALUE;
            enable_b_q <= IPL_RESET_VALUE;
            rdata_q    <= IPL_RESET_VALUE;
        end else begin
            high_a_q   <= high_a_d;
            low_a_q    <= low_a_d;
            high_b_q   <= high_b_d;
            low_b_q    <= low_b_d;
            enable_a_q <= enable_a_d;
            enable_b_q <= enable_b_d;
            rdata_q    <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // per-source vectors in polling order: seven core sources, then b[4:0], b[6]
    logic [IPL_NUM_SRC-1:0] msb_w;
    logic [IPL_NUM_SRC-1:0] lsb_w;
    logic [IPL_NUM_SRC-1:0] ena_w;
    logic [IPL_NUM_SRC-1:0] cand_w;
    assign msb_w  = {high_b_q[6], high_b_q[4:0], high_a_q[6:0]};
    assign lsb_w  = {low_b_q[6], low_b_q[4:0], low_a_q[6:0]};
    assign ena_w  = {enable_b_q[6], enable_b_q[4:0], enable_a_q[6:0]};
    // [RULE_08] global enable gates every individual enable
    assign cand_w = i_irq_pend & ena_w & {IPL_NUM_SRC{enable_a_q[IPL_GLOBAL_EN_BIT]}};

    // arbitration: highest level wins, earliest in polling order breaks ties
    logic                 win_found_w;
    logic [IPL_IDX_W-1:0] win_idx_w;
    logic [IPL_LVL_W-1:0] win_lvl_w;
    always_comb begin
        logic [IPL_LVL_W-1:0] lvl;
        lvl         = '0;
        win_found_w = 1'b0;
        win_idx_w   = '0;
        win_lvl_w   = '0;
        for (int i = 0; i < IPL_NUM_SRC; i++) begin
            // [RULE_05] high bit is MSB, low bit is LSB
            lvl = {msb_w[i], lsb_w[i]};
            // [RULE_09] strict greater keeps the earlier source on a tie
            if (cand_w[i] && (!win_found_w || lvl > win_lvl_w)) begin
                win_found_w = 1'b1;
                win_idx_w   = IPL_IDX_W'(i);
                win_lvl_w   = lvl;
            end
        end
    end

    // highest level currently in service
    logic                 svc_any_w;
    logic [IPL_LVL_W-1:0] svc_top_w;
    always_comb begin
        svc_any_w = 1'b0;
        svc_top_w = '0;
        for (int l = 0; l < IPL_NUM_LVL; l++) begin
            if (o_in_service[l]) begin
                svc_any_w = 1'b1;
                svc_top_w = IPL_LVL_W'(l);
            end
        end
    end

    // request to the core and in-service tracking
    logic                   valid_q, valid_d;
    logic [IPL_IDX_W-1:0]   index_q, index_d;
    logic [IPL_LVL_W-1:0]   level_q, level_d;
    logic [IPL_NUM_LVL-1:0] svc_q, svc_d;
    always_comb begin
        // [RULE_09] only a strictly higher level preempts a running routine
        valid_d = win_found_w && (!svc_any_w || win_lvl_w > svc_top_w);
        index_d = win_idx_w;
        level_d = win_lvl_w;
        svc_d   = svc_q;
        // return clears the top level first so an ack in the same cycle wins
        if (i_irq_ret && svc_any_w) begin
            svc_d[svc_top_w] = 1'b0;
        end
        // [RULE_09] vectoring marks the granted level as in service
        if (i_irq_ack && valid_q) begin
            svc_d[level_q] = 1'b1;
        end
    end

    // arbitration output flops; the core sees the winner one cycle late
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            valid_q <= 1'b0;
            index_q <= '0;
            level_q <= '0;
            svc_q   <= '0;
        end else begin
            valid_q <= valid_d;
            index_q <= index_d;
            level_q <= level_d;
            svc_q   <= svc_d;
        end
    end

    assign o_irq_valid  = valid_q;
    assign o_irq_index  = index_q;
    assign o_irq_level  = level_q;
    assign o_in_service = svc_q;

    // checks on the register file and arbitration
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    high_a_write_a: assert property ( // RULE_01
        i_wr && i_addr == IPL_ADDR_HIGH_A |=> high_a_q == ($past(i_wdata) & IPL_MASK_A))
        else $error("first high register did not store write");

    low_a_read_a: assert property ( // RULE_02
        i_rd && i_addr == IPL_ADDR_LOW_A && !i_wr
        |=> o_rdata == ($past(low_a_q) & IPL_MASK_A))
        else $error("first low register read mismatch");

    high_b_write_a: assert property ( // RULE_03
        i_wr && i_addr == IPL_ADDR_HIGH_B ##1 i_rd && i_addr == IPL_ADDR_HIGH_B
        |=> o_rdata == ($past(i_wdata, 2) & IPL_MASK_B))
        else $error("second high register write then read mismatch");

    low_b_read_a: assert property ( // RULE_04
        i_rd && i_addr == IPL_ADDR_LOW_B |=> o_rdata == ($past(low_b_q) & IPL_MASK_B))
        else $error("second low register read mismatch");

    level_form_a: assert property ( // RULE_05
        win_found_w |=> o_irq_level == {$past(msb_w[win_idx_w]), $past(lsb_w[win_idx_w])})
        else $error("level not formed from high and low bits");

    rsvd_a_zero_a: assert property ( // RULE_06
        i_rd && (i_addr == IPL_ADDR_HIGH_A || i_addr == IPL_ADDR_LOW_A) |=> !o_rdata[7])
        else $error("reserved bit of first pair read one");

    rsvd_b_zero_a: assert property ( // RULE_07
        i_rd && (i_addr == IPL_ADDR_HIGH_B || i_addr == IPL_ADDR_LOW_B)
        |=> !o_rdata[7] && !o_rdata[5])
        else $error("reserved bits of second pair read one");

    global_off_a: assert property ( // RULE_08
        !enable_a_q[IPL_GLOBAL_EN_BIT] |=> !o_irq_valid)
        else $error("request raised with global enable clear");

    top_no_preempt_a: assert property ( // RULE_09
        svc_q[3] && !i_irq_ret |=> !o_irq_valid)
        else $error("level three routine was preempted");

    ack_marks_svc_a: assert property ( // RULE_09
        i_irq_ack && o_irq_valid |=> o_in_service[$past(o_irq_level)])
        else $error("acknowledged level not marked in service");

    // register storage: every write lands masked, reserved bits never hold a one
    low_a_write_a: assert property ( // RULE_02
        i_wr && i_addr == IPL_ADDR_LOW_A |=> low_a_q == ($past(i_wdata) & IPL_MASK_A))
        else $error("first low register did not store write");

    high_b_store_a: assert property ( // RULE_03
        i_wr && i_addr == IPL_ADDR_HIGH_B |=> high_b_q == ($past(i_wdata) & IPL_MASK_B))
        else $error("second high register did not store write");

    low_b_write_a: assert property ( // RULE_04
        i_wr && i_addr == IPL_ADDR_LOW_B |=> low_b_q == ($past(i_wdata) & IPL_MASK_B))
        else $error("second low register did not store write");

    high_a_read_a: assert property ( // RULE_01
        i_rd && i_addr == IPL_ADDR_HIGH_A |=> o_rdata == ($past(high_a_q) & IPL_MASK_A))
        else $error("first high register read mismatch");

    rsvd_a_held_a: assert property ( // RULE_06
        ((high_a_q | low_a_q) & ~IPL_MASK_A) == 8'h00)
        else $error("reserved bit of first pair holds a one");

    rsvd_b_held_a: assert property ( // RULE_07
        ((high_b_q | low_b_q) & ~IPL_MASK_B) == 8'h00)
        else $error("reserved bits of second pair hold a one");

    enable_b_store_a: assert property ( // RULE_08
        i_wr && i_addr == IPL_ADDR_ENABLE_B
        |=> enable_b_q == ($past(i_wdata) & IPL_MASK_ENABLE_B))
        else $error("second enable register did not store write");

    no_cand_idle_a: assert property ( // RULE_08
        cand_w == '0 |=> !o_irq_valid)
        else $error("request raised with no enabled pending source");

    // arbitration against the levels already in service
    preempt_above_a: assert property ( // RULE_09
        o_irq_valid && $past(svc_any_w) |-> o_irq_level > $past(svc_top_w))
        else $error("request did not exceed the level in service");

    first_top_wins_a: assert property ( // RULE_09
        cand_w[0] && msb_w[0] && lsb_w[0] |=> o_irq_index == '0)
        else $error("earliest top level source lost arbitration");

    ret_clears_top_a: assert property ( // RULE_09
        i_irq_ret && svc_any_w && !(i_irq_ack && o_irq_valid)
        |=> !o_in_service[$past(svc_top_w)])
        else $error("return did not close the top level");

    ack_ignored_a: assert property ( // RULE_09
        i_irq_ack && !o_irq_valid && !i_irq_ret |=> o_in_service == $past(o_in_service))
        else $error("acknowledge without a request changed the service state");

    cov_grant_top: cover property (o_irq_valid && o_irq_level == 2'h3);
    cov_preempt: cover property (svc_q[0] && o_irq_valid && o_irq_level == 2'h2);
    cov_nested_ret: cover property (svc_q[1] && svc_q[2] ##1 i_irq_ret);
    cov_ack_with_ret: cover property (i_irq_ack && o_irq_valid && i_irq_ret);
    cov_global_off: cover property (!enable_a_q[IPL_GLOBAL_EN_BIT] && i_irq_pend != '0);

endmodule
`default_nettype wire

// file: verif/ipl_core_model.sv
// core-side stand-in: takes offered requests after a chosen delay and returns on command
`timescale 1ns/1ps
`default_nettype none
module ipl_core_model (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_arst_n,
    // bench control
    input  wire logic       i_go,
    input  wire logic [1:0] i_delay,
    input  wire logic       i_ret_req,
    // block side
    input  wire logic       i_irq_valid,
    output logic            o_irq_ack,
    output logic            o_irq_ret
);
    logic       armed_q;
    logic [1:0] cnt_q;

    // one ack per arming, so a stale valid after the ack cannot cause a second one
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            armed_q   <= 1'b0;
            cnt_q     <= 2'h0;
            o_irq_ack <= 1'b0;
            o_irq_ret <= 1'b0;
        end else begin
            o_irq_ret <= i_ret_req;
            o_irq_ack <= 1'b0;
            if (i_go) begin
                armed_q <= 1'b1;
                cnt_q   <= i_delay;
            end else if (armed_q && i_irq_valid) begin
                if (cnt_q == 2'h0) begin
                    o_irq_ack <= 1'b1;
                    armed_q   <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/ipl_levels_tb.sv
// self-checking bench for the interrupt priority level block
`timescale 1ns/1ps
`default_nettype none
module ipl_levels_tb;
    import ipl_pkg::*;
    logic        clk_sys = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, ret_req = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, ha, la, hb, lb, ea, eb;
    logic [12:0] pend = 13'h0000;
    logic [1:0]  dly = 2'h0, lvl;
    logic [3:0]  idx, insvc;
    logic        ack, ret, vld;
    int          fail_count = 0, n_tests = 0;
    int          svc_stack [$];
    logic [7:0]  map [6] = '{IPL_ADDR_HIGH_A, IPL_ADDR_LOW_A, IPL_ADDR_HIGH_B, IPL_ADDR_LOW_B,
                             IPL_ADDR_ENABLE_A, IPL_ADDR_ENABLE_B};
    logic [7:0]  msk [6] = '{IPL_MASK_A, IPL_MASK_A, IPL_MASK_B, IPL_MASK_B,
                             IPL_MASK_ENABLE_A, IPL_MASK_ENABLE_B};

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    ipl_levels ipl_levels_i (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_irq_pend(pend),
        .i_irq_ack(ack), .i_irq_ret(ret), .o_irq_valid(vld), .o_irq_index(idx),
        .o_irq_level(lvl), .o_in_service(insvc));
    ipl_core_model ipl_core_model_i (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_go(go),
        .i_delay(dly), .i_ret_req(ret_req), .i_irq_valid(vld), .o_irq_ack(ack), .o_irq_ret(ret));

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // expected in-service bits: one per acknowledged level still on the stack
    function automatic logic [7:0] svc_bits();
        logic [7:0] b;
        b = 8'h00;
        foreach (svc_stack[k]) b[svc_stack[k]] = 1'b1;
        return b;
    endfunction

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so it is looked at there
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 chk("read data", exp, rdata);
    endtask

    task automatic load_all();
        wr_reg(IPL_ADDR_HIGH_A, ha);
        wr_reg(IPL_ADDR_LOW_A, la);
        wr_reg(IPL_ADDR_HIGH_B, hb);
        wr_reg(IPL_ADDR_LOW_B, lb);
        wr_reg(IPL_ADDR_ENABLE_A, ea);
        wr_reg(IPL_ADDR_ENABLE_B, eb);
    endtask

    // reference: highest level wins, strict compare keeps ties in polling order
    task automatic arb_check();
        int best;
        int bl;
        int l;
        int p;
        best = -1;
        bl = -1;
        for (int i = 0; i < 13; i++) begin
            p = (i < 7) ? i : ((i == 12) ? 6 : i - 7);
            l = (i < 7) ? ha[p] * 2 + la[p] : hb[p] * 2 + lb[p];
            if (pend[i] && ea[7] && ((i < 7) ? ea[p] : eb[p]) && l > bl) begin
                best = i;
                bl = l;
            end
        end
        chk("valid", {7'h00, best >= 0}, {7'h00, vld});
        if (best >= 0) begin
            chk("index", 8'(best), {4'h0, idx});
            chk("level", 8'(bl), {6'h00, lvl});
        end
    endtask

    // a hang is cut off well beyond the roughly 700 cycles the run needs
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    initial begin
        void'($urandom(42401));
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        // zero after reset, unmapped place ignored, software never sets a reserved bit
        for (int i = 0; i < 6; i++) begin
            rd_reg(map[i], IPL_RESET_VALUE);
            wr_reg(map[i], msk[i]);
            rd_reg(map[i], msk[i]);
        end
        wr_reg(8'hB4, 8'hFF);
        rd_reg(8'hB4, 8'h00);
        // random levels, enables and requests; software keeps reserved bits at zero
        for (int n = 0; n < 40; n++) begin
            ha = 8'($urandom) & IPL_MASK_A;
            la = 8'($urandom) & IPL_MASK_A;
            hb = 8'($urandom) & IPL_MASK_B;
            lb = 8'($urandom) & IPL_MASK_B;
            ea = {n % 4 != 0, 7'($urandom)};
            eb = 8'($urandom) & IPL_MASK_ENABLE_B;
            load_all();
            pend <= 13'($urandom);
            repeat (3) @(posedge clk_sys);
            #1 arb_check();
        end
        // ext0 at level 1 is taken slowly, then audio at level 3 cuts in
        ha = 8'h40;
        la = 8'h41;
        hb = 8'h00;
        lb = 8'h00;
        ea = 8'hC1;
        eb = 8'h00;
        load_all();
        pend <= 13'h0001;
        dly  <= 2'h3;
        go   <= 1'b1;
        @(posedge clk_sys);
        go   <= 1'b0;
        repeat (8) @(posedge clk_sys);
        svc_stack.push_back(int'({ha[0], la[0]}));
        #1 chk("in service", svc_bits(), {4'h0, insvc});
        chk("valid", 8'h00, {7'h00, vld});
        @(posedge clk_sys);
        pend <= 13'h0041;
        dly  <= 2'h2;
        go   <= 1'b1;
        @(posedge clk_sys);
        go   <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk("index", 8'h06, {4'h0, idx});
        chk("level", 8'h03, {6'h00, lvl});
        repeat (5) @(posedge clk_sys);
        svc_stack.push_back(int'({ha[6], la[6]}));
        #1 chk("in service", svc_bits(), {4'h0, insvc});
        @(posedge clk_sys);
        pend <= 13'h0000;
        // each return closes the highest level in service
        for (int r = 0; r < 2; r++) begin
            @(posedge clk_sys);
            ret_req <= 1'b1;
            @(posedge clk_sys);
            ret_req <= 1'b0;
            repeat (3) @(posedge clk_sys);
            void'(svc_stack.pop_back());
            #1 chk("in service", svc_bits(), {4'h0, insvc});
        end
        // ext0 is offered again once nothing is in service
        @(posedge clk_sys);
        pend <= 13'h0001;
        repeat (2) @(posedge clk_sys);
        #1 chk("valid", 8'h01, {7'h00, vld});
        // a reset in mid-run clears the request, the service state and the registers
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        #1 chk("valid", 8'h00, {7'h00, vld});
        chk("in service", 8'h00, {4'h0, insvc});
        rd_reg(IPL_ADDR_HIGH_A, IPL_RESET_VALUE);
        stop_test();
    end
endmodule
`default_nettype wire
